/* File: fanout_cfg.svh */
// Constants of the clock fan-out output control.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef FANOUT_CFG_SVH
`define FANOUT_CFG_SVH

// System clock period in ns
`define MCLK_PERIOD_NS      40
// Least power-up delay in ns, then in cycles rounded up
`define POWERUP_DELAY_NS    200000
`define POWERUP_DELAY_CYC   ((`POWERUP_DELAY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
// Width of the power-up delay counter
`define DELAY_CNT_W         16
// Zero value of the delay counter
`define DELAY_CNT_ZERO      16'h0000
// Rising edges of the input clock that make it valid
`define CLK_VALID_EDGES     4'h4
// Zero value of the edge counter
`define EDGE_CNT_ZERO       4'h0

`endif

/* File: fanout_pkg.sv */
// Types of the clock fan-out output control.
// Shared by the top module and the output gate.
package fanout_pkg;

    typedef enum logic [1:0] {
        state_power_off        = 2'b00,
        state_powerup_delay    = 2'b01,
        state_wait_input_clock = 2'b10,
        state_operating        = 2'b11
    } seq_state_t;

    typedef enum logic [1:0] {
        gate_off  = 2'b00,
        gate_park = 2'b01,
        gate_run  = 2'b10
    } gate_state_t;

endpackage : fanout_pkg

/* File: ref_share_if.sv */
// Interface carrying the sampled reference clock and sequencer state.
// Driven by the top module, read by each output gate.
`timescale 1ns/1ps
`default_nettype none

interface ref_share_if;
    logic ref_level;
    logic operating;

    modport src (output ref_level, output operating);
    modport dst (input  ref_level, input  operating);
endinterface : ref_share_if

`default_nettype wire

/* File: out_gate.sv */
// One output pair with its own active-low enable and glitch-free gating.
// Assumes ref_level is already synchronised to mclk_i.
`timescale 1ns/1ps
`default_nettype none

module out_gate
    import fanout_pkg::*;
(
    input  wire logic   mclk_i,
    input  wire logic   resetn_i,
    input  wire logic   enable_n_i,
    ref_share_if.dst    share,
    output logic        clk_p_o,
    output logic        clk_n_o,
    output logic        clk_oe_o
);

    logic        en_n_s1_q;
    logic        en_n_s2_q;
    gate_state_t state_q;
    gate_state_t state_d;
    logic        p_q;
    logic        p_d;
    logic        n_q;
    logic        n_d;
    logic        oe_q;
    logic        oe_d;
    logic        want;

    // Two-stage enable synchroniser
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_n_s1_q <= 1'b1;
            en_n_s2_q <= 1'b1;
        end else begin
            en_n_s1_q <= enable_n_i;
            en_n_s2_q <= en_n_s1_q;
        end
    end

    // Low enables the pair, only once operating
    assign want = !en_n_s2_q && share.operating;

    always_comb begin
        state_d = state_q;
        p_d     = p_q;
        n_d     = n_q;
        oe_d    = oe_q;
        unique case (state_q)
            gate_off: begin
                p_d  = 1'b0;
                n_d  = 1'b0;
                oe_d = 1'b0;
                if (want) begin
                    // Drive true line high before clocking
                    state_d = gate_park;
                    p_d     = 1'b1;
                    n_d     = 1'b0;
                    oe_d    = 1'b1;
                end
            end
            gate_park: begin
                if (!want) begin
                    state_d = gate_off;
                    p_d     = 1'b0;
                    oe_d    = 1'b0;
                end else if (share.ref_level) begin
                    // Join the clock while high, no runt
                    state_d = gate_run;
                end
            end
            gate_run: begin
                p_d = share.ref_level;
                n_d = !share.ref_level;
                if (!share.operating) begin
                    state_d = gate_off;
                    p_d     = 1'b0;
                    n_d     = 1'b0;
                    oe_d    = 1'b0;
                end else if (!want && !share.ref_level) begin
                    // Release only in the low phase
                    state_d = gate_off;
                    p_d     = 1'b0;
                    n_d     = 1'b0;
                    oe_d    = 1'b0;
                end
            end
            default: begin
                state_d = gate_off;
                p_d     = 1'b0;
                n_d     = 1'b0;
                oe_d    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= gate_off;
            p_q     <= 1'b0;
            n_q     <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            p_q     <= p_d;
            n_q     <= n_d;
            oe_q    <= oe_d;
        end
    end

    assign clk_p_o  = p_q;
    assign clk_n_o  = n_q;
    assign clk_oe_o = oe_q;

endmodule : out_gate

`default_nettype wire

/* File: clock_fanout_output_enable.sv */
// Output control of a two-pair reference clock fan-out buffer.
// Assumes ref_clock_in, supply detect and enables are asynchronous pins.
//
// Overview of operation
// - On supply detected, enter delay state and wait 0.2 ms before advancing.
// - After the delay, wait with outputs disabled for a valid input clock.
// - On valid input clock, enter operating state; outputs follow their enables.
// - Each pair has active-low enable: low drives, high tri-states both lines.
// - Enables change anytime; synchronise them before use.
// - Enabled pair resumes clocking glitch-free, 2 to 6 input periods later; code takes 3 mclk_i cycles, then waits for a high reference.
// - On enable, leave tri-state and drive true line high before clocking.
// - Disabled pair stops glitch-free and tri-states 2 to 6 periods later; code takes at least 3 mclk_i cycles, then waits for a low reference.
// - Each enabled pair carries a copy of the input reference clock.
`timescale 1ns/1ps
`default_nettype none
`include "fanout_cfg.svh"

module clock_fanout_output_enable
    import fanout_pkg::*;
#(
    parameter int POWERUP_DELAY_CYCLES = `POWERUP_DELAY_CYC
)
(
    input  wire logic   mclk_i,
    input  wire logic   resetn_i,
    input  wire logic   supply_good_i,
    input  wire logic   ref_clock_in_i,
    input  wire logic   out1_enable_n_i,
    input  wire logic   out2_enable_n_i,
    output logic        buffered_clock_out1_p_o,
    output logic        buffered_clock_out1_n_o,
    output logic        buffered_clock_out1_oe_o,
    output logic        buffered_clock_out2_p_o,
    output logic        buffered_clock_out2_n_o,
    output logic        buffered_clock_out2_oe_o,
    output logic        operating_o
);

    ref_share_if share ();

    logic                       sup_s1_q;
    logic                       sup_s2_q;
    logic                       ref_s1_q;
    logic                       ref_s2_q;
    logic                       ref_s3_q;
    logic                       ref_rise;
    seq_state_t                 state_q;
    seq_state_t                 state_d;
    logic [`DELAY_CNT_W-1:0]    delay_q;
    logic [`DELAY_CNT_W-1:0]    delay_d;
    logic [3:0]                 edges_q;
    logic [3:0]                 edges_d;
    logic                       oper_q;
    logic                       oper_d;

    // Pin synchronisers
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
        end else begin
            sup_s1_q <= supply_good_i;
            sup_s2_q <= sup_s1_q;
            ref_s1_q <= ref_clock_in_i;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
        end
    end

    assign ref_rise = ref_s2_q && !ref_s3_q;

    // Power-up sequencer
    always_comb begin
        state_d = state_q;
        delay_d = delay_q;
        edges_d = edges_q;
        oper_d  = 1'b0;
        unique case (state_q)
            state_power_off: begin
                delay_d = `DELAY_CNT_ZERO;
                edges_d = `EDGE_CNT_ZERO;
                if (sup_s2_q) begin
                    state_d = state_powerup_delay;
                end
            end
            state_powerup_delay: begin
                edges_d = `EDGE_CNT_ZERO;
                if (delay_q >= `DELAY_CNT_W'(POWERUP_DELAY_CYCLES - 1)) begin
                    state_d = state_wait_input_clock;
                end else begin
                    delay_d = delay_q + `DELAY_CNT_W'(1);
                end
            end
            state_wait_input_clock: begin
                // Count input clock edges for validity
                if (ref_rise) begin
                    edges_d = edges_q + 4'h1;
                    if (edges_q + 4'h1 >= `CLK_VALID_EDGES) begin
                        state_d = state_operating;
                        oper_d  = 1'b1;
                    end
                end
            end
            state_operating: begin
                oper_d = 1'b1;
            end
        endcase
        if (!sup_s2_q) begin
            state_d = state_power_off;
            delay_d = `DELAY_CNT_ZERO;
            edges_d = `EDGE_CNT_ZERO;
            oper_d  = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= state_power_off;
            delay_q <= `DELAY_CNT_ZERO;
            edges_q <= `EDGE_CNT_ZERO;
            oper_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            delay_q <= delay_d;
            edges_q <= edges_d;
            oper_q  <= oper_d;
        end
    end

    assign share.ref_level = ref_s2_q;
    assign share.operating = oper_q;
    assign operating_o     = oper_q;

    // One gate per output pair
    out_gate u_gate1 (
        .mclk_i     (mclk_i),
        .resetn_i   (resetn_i),
        .enable_n_i (out1_enable_n_i),
        .share      (share),
        .clk_p_o    (buffered_clock_out1_p_o),
        .clk_n_o    (buffered_clock_out1_n_o),
        .clk_oe_o   (buffered_clock_out1_oe_o)
    );

    out_gate u_gate2 (
        .mclk_i     (mclk_i),
        .resetn_i   (resetn_i),
        .enable_n_i (out2_enable_n_i),
        .share      (share),
        .clk_p_o    (buffered_clock_out2_p_o),
        .clk_n_o    (buffered_clock_out2_n_o),
        .clk_oe_o   (buffered_clock_out2_oe_o)
    );

endmodule : clock_fanout_output_enable

`default_nettype wire

/* File: clock_fanout_output_enable_assertions.sv */
// Checker of the fan-out control pins.
// Sees only the top module's ports; bound to the top below.
`timescale 1ns/1ps
`default_nettype none
module fanout_checker #(parameter int POWERUP_DELAY_CYCLES = 5000) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic supply_good_i,
    input wire logic ref_clock_in_i,
    input wire logic out1_enable_n_i,
    input wire logic out2_enable_n_i,
    input wire logic buffered_clock_out1_p_o,
    input wire logic buffered_clock_out1_n_o,
    input wire logic buffered_clock_out1_oe_o,
    input wire logic buffered_clock_out2_p_o,
    input wire logic buffered_clock_out2_n_o,
    input wire logic buffered_clock_out2_oe_o,
    input wire logic operating_o
);
    wire logic p1 = buffered_clock_out1_p_o;
    wire logic n1 = buffered_clock_out1_n_o;
    wire logic oe1 = buffered_clock_out1_oe_o;
    wire logic p2 = buffered_clock_out2_p_o;
    wire logic n2 = buffered_clock_out2_n_o;
    wire logic oe2 = buffered_clock_out2_oe_o;
    wire logic en1 = out1_enable_n_i;
    logic [31:0] up_q, up_d;
    logic [3:0]  rc_q, rc_d;
    logic        rp_q;
    // Cycles with supply up, and reference rises after the delay
    always_comb begin
        up_d = supply_good_i ? up_q + 32'h0000_0001 : 32'h0000_0000;
        rc_d = supply_good_i ? rc_q : 4'h0;
        if (supply_good_i && ref_clock_in_i && !rp_q && rc_q != 4'h8
            && int'(up_q) > POWERUP_DELAY_CYCLES + 2) begin
            rc_d = rc_q + 4'h1;
        end
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {up_q, rc_q, rp_q} <= '0;
        end else begin
            {up_q, rc_q, rp_q} <= {up_d, rc_d, ref_clock_in_i};
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_on1; operating_o && $fell(en1); endsequence
    sequence s_off1; $rose(en1) ##1 en1; endsequence
    AST_OFF_TRISTATE: assert property (!operating_o && !$past(operating_o) |-> !oe1 && !oe2)
        else $error("pair driven outside operating state");
    AST_PARK_HIGH: assert property ($rose(oe1) |-> p1 && !n1 && !$past(en1, 2))
        else $error("true line not high when pair starts driving");
    AST_EN_LATENCY: assert property (s_on1 |-> ##[1:4] oe1)
        else $error("pair not driving after enable");
    AST_DIS_LATENCY: assert property (s_off1 |-> ##[0:16] !oe1)
        else $error("pair not released after disable");
    AST_PAIR_LEVELS: assert property ((oe1 ? n1 != p1 : !p1 && !n1)
        && (oe2 ? n2 != p2 : !p2 && !n2))
        else $error("pair lines inconsistent");
    AST_COPY: assert property (oe1 && $past(oe1) && $rose(p1) |-> $past(ref_clock_in_i, 3))
        else $error("output rise without reference rise");
    AST_DELAY: assert property ($rose(operating_o) |-> int'(up_q) > POWERUP_DELAY_CYCLES)
        else $error("operating before power-up delay");
    AST_WAIT_CLOCK: assert property ($rose(operating_o) |-> rc_q >= 4'h4)
        else $error("operating without valid reference");
    AST_OPERATE: assert property (rc_q == 4'h8 |-> operating_o)
        else $error("not operating with valid reference");
    AST_SUPPLY_LOSS: assert property (!supply_good_i [*6] |-> !operating_o)
        else $error("operating without supply");
endmodule : fanout_checker

bind clock_fanout_output_enable fanout_checker #(
    .POWERUP_DELAY_CYCLES(POWERUP_DELAY_CYCLES)
) i_chk (.mclk_i, .resetn_i, .supply_good_i, .ref_clock_in_i, .out1_enable_n_i,
    .out2_enable_n_i, .buffered_clock_out1_p_o, .buffered_clock_out1_n_o,
    .buffered_clock_out1_oe_o, .buffered_clock_out2_p_o, .buffered_clock_out2_n_o,
    .buffered_clock_out2_oe_o, .operating_o);
`default_nettype wire

/* File: board_model.sv */
// Board side: reference clock source and load on both true lines.
// Clock stands low while run_i is low.
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input  wire logic run_i,
    input  wire logic p1_i,
    input  wire logic oe1_i,
    input  wire logic p2_i,
    input  wire logic oe2_i,
    output logic      ref_clk_o,
    output int        rise1_o,
    output int        rise2_o
);
    wire logic line1 = oe1_i ? p1_i : 1'bz;
    wire logic line2 = oe2_i ? p2_i : 1'bz;
    initial begin
        ref_clk_o = 1'b0;
        #7;
        forever begin
            #160;
            ref_clk_o = run_i ? ~ref_clk_o : 1'b0;
        end
    end
    // Rising edges seen on each driven line
    always @(posedge line1) if (line1 === 1'b1) rise1_o++;
    always @(posedge line2) if (line2 === 1'b1) rise2_o++;
endmodule : board_model
`default_nettype wire

/* File: test_clock_fanout_output_enable.sv */
// Self-checking bench of the fan-out output control.
// Board model drives the reference clock; checker is bound to the top.
`timescale 1ns/1ps
`default_nettype none
module test_clock_fanout_output_enable;
    localparam int DLY = 20;
    logic       mclk_i, resetn_i, supply, run, en1_n, en2_n;
    logic       p1, n1, oe1, p2, n2, oe2, oper, refc;
    logic [2:0] notes[$];
    logic [2:0] prev, got;
    int         r1, r2, c1, c2, cyc = 0, n_errors = 0, total_checks = 0;
    wire logic [2:0] cur = {oper, oe1, oe2};

    clock_fanout_output_enable #(.POWERUP_DELAY_CYCLES(DLY)) i_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .supply_good_i(supply), .ref_clock_in_i(refc),
        .out1_enable_n_i(en1_n), .out2_enable_n_i(en2_n), .buffered_clock_out1_p_o(p1),
        .buffered_clock_out1_n_o(n1), .buffered_clock_out1_oe_o(oe1),
        .buffered_clock_out2_p_o(p2), .buffered_clock_out2_n_o(n2),
        .buffered_clock_out2_oe_o(oe2), .operating_o(oper));
    board_model i_board (.run_i(run), .p1_i(p1), .oe1_i(oe1), .p2_i(p2), .oe2_i(oe2),
        .ref_clk_o(refc), .rise1_o(r1), .rise2_o(r2));

    task automatic err(input string m);
        n_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask : err
    task automatic chk(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1) err(m);
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // Toggle one enable, note the pair's expected drive state
    task automatic flip(input int k, input int hold);
        @(negedge mclk_i);
        if (k == 1) begin
            en1_n = ~en1_n;
            notes.push_back({2'h1, ~en1_n});
        end else begin
            en2_n = ~en2_n;
            notes.push_back({2'h2, ~en2_n});
        end
        repeat (hold) @(negedge mclk_i);
    endtask : flip

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err("timeout");
            wrap_up();
        end
    end
    // Each change of operating or a drive state takes the oldest note
    initial begin
        prev = 3'h0;
        forever begin
            @(posedge mclk_i);
            #1;
            for (int k = 0; k < 3; k++) begin
                if (cur[2-k] !== prev[2-k]) begin
                    got = {k[1:0], cur[2-k]};
                    total_checks++;
                    if (notes.size() == 0 || notes[0] !== got) err("unexpected change");
                    if (notes.size() != 0) void'(notes.pop_front());
                end
            end
            total_checks++;
            if (oe1 ? n1 !== ~p1 : (n1 | p1) !== 1'b0) err("pair 1 lines wrong");
            if (oe2 ? n2 !== ~p2 : (n2 | p2) !== 1'b0) err("pair 2 lines wrong");
            prev = cur;
        end
    end

    initial begin
        resetn_i = 1'b0;
        supply = 1'b0;
        run = 1'b1;
        en1_n = 1'b0;
        en2_n = 1'b0;
        void'($urandom(66957));
        repeat (4) @(negedge mclk_i);
        resetn_i = 1'b1;
        repeat (10) @(negedge mclk_i);
        supply = 1'b1;
        repeat (DLY - 4) @(negedge mclk_i);
        run = 1'b0;
        repeat (DLY + 80) @(negedge mclk_i);
        chk(oper === 1'b0, "operating without reference");
        notes = {3'h1, 3'h3, 3'h5};
        run = 1'b1;
        repeat (60) @(negedge mclk_i);
        chk(notes.size() == 0, "power-up sequence incomplete");
        repeat (8) flip($urandom_range(2, 1), $urandom_range(60, 30));
        if (en1_n) flip(1, 40);
        if (en2_n) flip(2, 40);
        chk(notes.size() == 0, "enable changes not seen");
        c1 = r1;
        c2 = r2;
        repeat (128) @(negedge mclk_i);
        chk((r1 - c1) inside {[15:17]} && (r2 - c2) inside {[15:17]}, "output rate");
        notes = {3'h0, 3'h2, 3'h4};
        supply = 1'b0;
        repeat (40) @(negedge mclk_i);
        en1_n = 1'b1;
        repeat (20) @(negedge mclk_i);
        en1_n = 1'b0;
        repeat (20) @(negedge mclk_i);
        chk(notes.size() == 0, "pairs not released on supply loss");
        wrap_up();
    end
endmodule : test_clock_fanout_output_enable
`default_nettype wire
